/* File: hw/gauge_status_and_output_regs.sv */
// Purpose: Status flags, algorithm outputs and cell-voltage tracking behind an APB slave.
// Assumes: Event inputs are one-cycle pulses synchronous to clk.
// Notes: Register byte address is four times the register index.
//
// Summary of operation
// [RL1] Algorithm outputs valid 351ms after configuration.
// [RL2] Time to empty meaningful only while discharging.
// [RL3] Time to full meaningful only while charging.
// [RL4] Cycle count steps one percent per LSB.
// [RL5] Power-on flag set on any reset event.
// [RL6] Current low/high flags follow thresholds, clear at reset.
// [RL7] Voltage low/high flags follow thresholds, clear at reset.
// [RL8] Temperature low/high flags follow thresholds, clear at reset.
// [RL9] Charge low/high flags follow thresholds, clear at reset.
// [RL10] Absent bit shows battery presence, zero at reset.
// [RL11] One percent flag on integer crossing, set at reset.
// [RL12] Inserted flag set on insertion, zero at reset.
// [RL13] Removed flag set on removal, one at reset.
// [RL14] Bits 0, 4 and 5 are undefined.
// [RL15] Tracker starts with max 00h, min FFh.
// [RL16] Writing 0x00FF restarts voltage tracking.
// [RL17] Max and min are 8-bit, 20mV each.
// [RL18] Average voltage is a running average.
// [RL19] Remaining capacity is filtered against load steps.
// [RL20] Full capacity recomputed per completed charge.
// [RL21] Max in upper byte, min in lower.
// [RL22] Sticky bit picks manual or automatic flag clearing.
// [RL23] Write zero clears a flag; new events win.
// [RL24] Each update widens max and min as needed.
//
// Chosen here: the APB slave port.
module gauge_status_and_output_regs #(
  parameter int unsigned VALID_CYCLES = gauge_regs_pkg::VALID_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Gauge events and data
  input wire logic configDone,
  input wire logic porEvent,
  input wire logic measUpdate,
  input wire gauge_regs_pkg::meas_t meas,
  input wire logic algUpdate,
  input wire gauge_regs_pkg::alg_t alg,
  input wire logic chargeDone,
  input wire logic cycleStep,
  input wire logic insertEvent,
  input wire logic removeEvent,
  input wire logic batteryAbsent,
  // Block state
  output logic outputsValid
);
  import gauge_regs_pkg::*;

  logic [15:0] reported_capacity_r;
  logic [15:0] reported_charge_pct_r;
  logic [15:0] fullCap_r;
  logic [15:0] tte_r;
  logic [15:0] ttf_r;
  logic [15:0] cycles_r;
  logic [15:0] cellVolt_r;
  logic [15:0] avgVolt_r;
  logic [15:0] current_r;
  logic [7:0] maxVolt_r;
  logic [7:0] minVolt_r;
  logic [15:0] voltTh_r;
  logic [15:0] tempTh_r;
  logic [15:0] chgTh_r;
  logic [15:0] curTh_r;
  logic [3:0] alertCfg_r;
  logic porFlag_r;
  logic onePctFlag_r;
  logic insFlag_r;
  logic remFlag_r;
  logic battAbsent_r;
  logic [VALID_CNT_W-1:0] validCnt_r;
  logic valid_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic curLow, curHigh, voltLow, voltHigh, tempLow, tempHigh, chgLow, chgHigh;
  logic [15:0] statusView;
  logic [15:0] keepMask;
  logic [15:0] wrData;
  logic [7:0] regIdx;
  logic addrOk;
  logic hit;
  logic [15:0] readVal;
  logic wrEn;
  logic wrStatus;
  logic discharging;
  logic charging;

  // Moves cur toward tgt by a shifted share of the error, at least one step.
  function automatic logic [15:0] filterStep(input logic [15:0] cur, input logic [15:0] tgt,
                                             input int unsigned shift);
    logic signed [16:0] diff;
    logic signed [16:0] step;
    diff = $signed({1'b0, tgt}) - $signed({1'b0, cur});
    step = diff >>> shift;
    if (step == 17'sd0) begin
      step = diff;
    end
    return cur + step[15:0];
  endfunction : filterStep

  assign regIdx = paddr[9:2];
  assign addrOk = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign wrEn = psel && penable && pready_r && pwrite && hit;
  assign wrStatus = wrEn && (regIdx == IDX_FLAG_STATUS);
  assign wrData = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
  // A lane left out of the strobes keeps its flags rather than clearing them.
  assign keepMask = {pstrb[1] ? pwdata[15:8] : 8'hff, pstrb[0] ? pwdata[7:0] : 8'hff};
  assign discharging = current_r[15];
  assign charging = !current_r[15] && (current_r != 16'h0000);

  // Undefined bits read as zero.
  always_comb begin
    statusView = 16'h0000; // see [RL14]
    statusView[BIT_POR] = porFlag_r;
    statusView[BIT_CUR_LOW] = curLow;
    statusView[BIT_BATT_ABSENT] = battAbsent_r;
    statusView[BIT_CUR_HIGH] = curHigh;
    statusView[BIT_ONE_PCT] = onePctFlag_r;
    statusView[BIT_VOLT_LOW] = voltLow;
    statusView[BIT_TEMP_LOW] = tempLow;
    statusView[BIT_CHG_LOW] = chgLow;
    statusView[BIT_INSERTED] = insFlag_r;
    statusView[BIT_VOLT_HIGH] = voltHigh;
    statusView[BIT_TEMP_HIGH] = tempHigh;
    statusView[BIT_CHG_HIGH] = chgHigh;
    statusView[BIT_REMOVED] = remFlag_r;
  end

  // Capacity, charge and full capacity read as zero, and the two time outputs as FFFFh, until the validity delay has run out.
  always_comb begin
    hit = addrOk;
    readVal = 16'h0000;
    unique case (regIdx)
      IDX_FLAG_STATUS: readVal = statusView;
      IDX_REPORTED_CAPACITY: readVal = valid_r ? reported_capacity_r : 16'h0000; // see [RL1]
      IDX_REPORTED_CHARGE_PCT: readVal = valid_r ? reported_charge_pct_r : 16'h0000;
      IDX_CELL_VOLTAGE: readVal = cellVolt_r;
      IDX_REPORTED_FULL_CAPACITY: readVal = valid_r ? fullCap_r : 16'h0000;
      IDX_TIME_TO_EMPTY: readVal = (valid_r && discharging) ? tte_r : TIME_NOT_AVAILABLE; // see [RL2]
      IDX_CYCLE_COUNT: readVal = cycles_r;
      IDX_AVERAGE_CELL_VOLTAGE: readVal = avgVolt_r;
      IDX_VOLTAGE_PEAK_TRACKER: readVal = {maxVolt_r, minVolt_r}; // see [RL21]
      IDX_TIME_TO_FULL: readVal = (valid_r && charging) ? ttf_r : TIME_NOT_AVAILABLE; // see [RL3]
      IDX_VOLTAGE_ALERT_THRESHOLDS: readVal = voltTh_r;
      IDX_TEMPERATURE_ALERT_THRESHOLDS: readVal = tempTh_r;
      IDX_CHARGE_ALERT_THRESHOLDS: readVal = chgTh_r;
      IDX_CURRENT_ALERT_THRESHOLDS: readVal = curTh_r;
      IDX_ALERT_CONFIG: readVal = {12'h000, alertCfg_r};
      IDX_BLOCK_STATE: readVal = {15'h0000, valid_r};
      default: hit = 1'b0;
    endcase
  end

  // APB answer: ready in the first access cycle, so every transfer takes two cycles.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        pslverr_r <= !hit;
        prdata_r <= (hit && !pwrite) ? {16'h0000, readVal} : 32'h0000_0000;
      end
    end
  end

  // Validity timer restarts whenever configuration is withdrawn.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      validCnt_r <= '0;
      valid_r <= 1'b0;
    end else if (!configDone) begin
      validCnt_r <= '0;
      valid_r <= 1'b0;
    end else if (validCnt_r == VALID_CNT_W'(VALID_CYCLES)) begin
      valid_r <= 1'b1; // see [RL1]
    end else begin
      validCnt_r <= validCnt_r + 1'b1;
    end
  end

  // Algorithm output registers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reported_capacity_r <= 16'h0000;
      reported_charge_pct_r <= 16'h0000;
      tte_r <= 16'h0000;
      ttf_r <= 16'h0000;
    end else if (algUpdate) begin
      reported_capacity_r <= filterStep(reported_capacity_r, alg.capacity, CAP_FILTER_SHIFT); // see [RL19]
      reported_charge_pct_r <= alg.chargePct;
      tte_r <= alg.timeEmpty;
      ttf_r <= alg.timeFull;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fullCap_r <= 16'h0000;
    end else if (chargeDone) begin
      fullCap_r <= alg.fullCap; // see [RL20]
    end
  end

  // Saturates rather than wrapping, so a long-lived cell never reads as new.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cycles_r <= 16'h0000;
    end else if (cycleStep && (cycles_r != CYCLE_COUNT_MAX)) begin
      cycles_r <= cycles_r + 16'h0001; // see [RL4]
    end
  end

  // Measurement registers and running average.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cellVolt_r <= 16'h0000;
      avgVolt_r <= 16'h0000;
      current_r <= 16'h0000;
    end else if (measUpdate) begin
      cellVolt_r <= meas.cellVolt;
      current_r <= meas.current;
      avgVolt_r <= filterStep(avgVolt_r, meas.cellVolt, AVG_FILTER_SHIFT); // see [RL18]
    end
  end

  // A host write takes priority over a measurement in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      maxVolt_r <= PEAK_TRACKER_RESET[15:8]; // see [RL15]
      minVolt_r <= PEAK_TRACKER_RESET[7:0]; // see [RL15]
    end else if (wrEn && (regIdx == IDX_VOLTAGE_PEAK_TRACKER)) begin
      maxVolt_r <= wrData[15:8]; // see [RL16]
      minVolt_r <= wrData[7:0]; // see [RL16]
    end else if (measUpdate) begin
      if (meas.voltQuant > maxVolt_r) begin
        maxVolt_r <= meas.voltQuant; // see [RL24] [RL17]
      end
      if (meas.voltQuant < minVolt_r) begin
        minVolt_r <= meas.voltQuant; // see [RL24] [RL17]
      end
    end
  end

  // Thresholds and alert configuration.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      voltTh_r <= UNSIGNED_THRESH_RESET;
      tempTh_r <= SIGNED_THRESH_RESET;
      chgTh_r <= UNSIGNED_THRESH_RESET;
      curTh_r <= SIGNED_THRESH_RESET;
      alertCfg_r <= ALERT_CONFIG_RESET;
    end else if (wrEn) begin
      if (regIdx == IDX_VOLTAGE_ALERT_THRESHOLDS) voltTh_r <= wrData;
      if (regIdx == IDX_TEMPERATURE_ALERT_THRESHOLDS) tempTh_r <= wrData;
      if (regIdx == IDX_CHARGE_ALERT_THRESHOLDS) chgTh_r <= wrData;
      if (regIdx == IDX_CURRENT_ALERT_THRESHOLDS) curTh_r <= wrData;
      if (regIdx == IDX_ALERT_CONFIG) alertCfg_r <= wrData[3:0];
    end
  end

  // Event flags: a zero written clears, a same-cycle event keeps the flag set.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      porFlag_r <= FLAG_STATUS_RESET[BIT_POR]; // see [RL5]
      onePctFlag_r <= FLAG_STATUS_RESET[BIT_ONE_PCT]; // see [RL11]
      insFlag_r <= FLAG_STATUS_RESET[BIT_INSERTED]; // see [RL12]
      remFlag_r <= FLAG_STATUS_RESET[BIT_REMOVED]; // see [RL13]
      battAbsent_r <= FLAG_STATUS_RESET[BIT_BATT_ABSENT]; // see [RL10]
    end else begin
      porFlag_r <= porEvent | (porFlag_r & !(wrStatus && !keepMask[BIT_POR])); // see [RL5] [RL23]
      onePctFlag_r <= (algUpdate && (alg.chargePct[15:8] != reported_charge_pct_r[15:8]))
                      | (onePctFlag_r & !(wrStatus && !keepMask[BIT_ONE_PCT])); // see [RL11]
      insFlag_r <= insertEvent
                   | (insFlag_r & !(wrStatus && !keepMask[BIT_INSERTED])); // see [RL12] [RL23]
      remFlag_r <= removeEvent
                   | (remFlag_r & !(wrStatus && !keepMask[BIT_REMOVED])); // see [RL13] [RL23]
      battAbsent_r <= batteryAbsent; // see [RL10]
    end
  end

  // Threshold flags for the four alert classes.
  alert_window_flags #(.SIGNED_CMP(1'b1)) u_curFlags ( // see [RL6]
    .clk(clk), .rst_b(rst_b), .sample(measUpdate), .value(meas.current[15:8]),
    .minTh(curTh_r[7:0]), .maxTh(curTh_r[15:8]), .sticky(alertCfg_r[CFG_CURRENT_STICKY]),
    .swWrite(wrStatus), .keepLow(keepMask[BIT_CUR_LOW]), .keepHigh(keepMask[BIT_CUR_HIGH]),
    .lowFlag_r(curLow), .highFlag_r(curHigh));

  alert_window_flags #(.SIGNED_CMP(1'b0)) u_voltFlags ( // see [RL7]
    .clk(clk), .rst_b(rst_b), .sample(measUpdate), .value(meas.cellVolt[15:8]),
    .minTh(voltTh_r[7:0]), .maxTh(voltTh_r[15:8]), .sticky(alertCfg_r[CFG_VOLTAGE_STICKY]),
    .swWrite(wrStatus), .keepLow(keepMask[BIT_VOLT_LOW]), .keepHigh(keepMask[BIT_VOLT_HIGH]),
    .lowFlag_r(voltLow), .highFlag_r(voltHigh));

  alert_window_flags #(.SIGNED_CMP(1'b1)) u_tempFlags ( // see [RL8]
    .clk(clk), .rst_b(rst_b), .sample(measUpdate), .value(meas.temp[15:8]),
    .minTh(tempTh_r[7:0]), .maxTh(tempTh_r[15:8]),
    .sticky(alertCfg_r[CFG_TEMPERATURE_STICKY]), .swWrite(wrStatus),
    .keepLow(keepMask[BIT_TEMP_LOW]), .keepHigh(keepMask[BIT_TEMP_HIGH]),
    .lowFlag_r(tempLow), .highFlag_r(tempHigh));

  alert_window_flags #(.SIGNED_CMP(1'b0)) u_chgFlags ( // see [RL9]
    .clk(clk), .rst_b(rst_b), .sample(algUpdate), .value(alg.chargePct[15:8]),
    .minTh(chgTh_r[7:0]), .maxTh(chgTh_r[15:8]), .sticky(alertCfg_r[CFG_CHARGE_STICKY]),
    .swWrite(wrStatus), .keepLow(keepMask[BIT_CHG_LOW]), .keepHigh(keepMask[BIT_CHG_HIGH]),
    .lowFlag_r(chgLow), .highFlag_r(chgHigh));

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign outputsValid = valid_r;

  property p_valid_bound;
    @(posedge clk) disable iff (!rst_b)
      (configDone && validCnt_r == VALID_CNT_W'(VALID_CYCLES)) |=> ##1 (outputsValid || !$past(configDone));
  endproperty
  a_valid_bound: assert property (p_valid_bound) else $error("Outputs not valid in time."); // see [RL1]

  property p_por_set;
    @(posedge clk) disable iff (!rst_b) porEvent |=> statusView[BIT_POR];
  endproperty
  a_por_set: assert property (p_por_set) else $error("Power-on flag not set."); // see [RL5]

  property p_one_pct;
    @(posedge clk) disable iff (!rst_b)
      (algUpdate && alg.chargePct[15:8] != reported_charge_pct_r[15:8]) |=> onePctFlag_r;
  endproperty
  a_one_pct: assert property (p_one_pct) else $error("Percent crossing missed."); // see [RL11]

  property p_set_wins;
    @(posedge clk) disable iff (!rst_b) (wrStatus && insertEvent) |=> statusView[BIT_INSERTED];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Insertion lost to clear."); // see [RL23]

  property p_max_track;
    @(posedge clk) disable iff (!rst_b)
      (measUpdate && !wrEn && meas.voltQuant > maxVolt_r) |=> maxVolt_r == $past(meas.voltQuant);
  endproperty
  a_max_track: assert property (p_max_track) else $error("Maximum not replaced."); // see [RL24]

  property p_restart;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && regIdx == IDX_VOLTAGE_PEAK_TRACKER && wrData == PEAK_TRACKER_RESET)
      |=> {maxVolt_r, minVolt_r} == 16'h00ff;
  endproperty
  a_restart: assert property (p_restart) else $error("Tracker not restarted."); // see [RL16]

  property p_cycle_step;
    @(posedge clk) disable iff (!rst_b)
      (cycleStep && cycles_r != CYCLE_COUNT_MAX) |=> cycles_r == $past(cycles_r) + 16'h0001;
  endproperty
  a_cycle_step: assert property (p_cycle_step) else $error("Cycle count did not step."); // see [RL4]

  property p_full_cap;
    @(posedge clk) disable iff (!rst_b) chargeDone |=> fullCap_r == $past(alg.fullCap);
  endproperty
  a_full_cap: assert property (p_full_cap) else $error("Full capacity not reloaded."); // see [RL20]

  property p_absent;
    @(posedge clk) disable iff (!rst_b) ##1 statusView[BIT_BATT_ABSENT] == $past(batteryAbsent);
  endproperty
  a_absent: assert property (p_absent) else $error("Absent bit wrong."); // see [RL10]

  property p_tte_gate;
    @(posedge clk) disable iff (!rst_b)
      (psel && !penable && !pwrite && regIdx == IDX_TIME_TO_EMPTY && addrOk && !discharging)
      |=> prdata_r[15:0] == TIME_NOT_AVAILABLE;
  endproperty
  a_tte_gate: assert property (p_tte_gate) else $error("Time to empty shown while idle."); // see [RL2]

endmodule : gauge_status_and_output_regs

/* File: hw/gauge_regs_pkg.sv */
// Purpose: Shared constants and carriers for the gauge status and output register bank.
// Assumes: APB register access with one aligned 32-bit word per register index.
// Notes: Byte address of a register is four times its index.
package gauge_regs_pkg;

  // Register indices; byte address = index * 4.
  localparam logic [7:0] IDX_FLAG_STATUS = 8'h00;
  localparam logic [7:0] IDX_REPORTED_CAPACITY = 8'h05;
  localparam logic [7:0] IDX_REPORTED_CHARGE_PCT = 8'h06;
  localparam logic [7:0] IDX_CELL_VOLTAGE = 8'h09;
  localparam logic [7:0] IDX_REPORTED_FULL_CAPACITY = 8'h10;
  localparam logic [7:0] IDX_TIME_TO_EMPTY = 8'h11;
  localparam logic [7:0] IDX_CYCLE_COUNT = 8'h17;
  localparam logic [7:0] IDX_AVERAGE_CELL_VOLTAGE = 8'h19;
  localparam logic [7:0] IDX_VOLTAGE_PEAK_TRACKER = 8'h1b;
  localparam logic [7:0] IDX_TIME_TO_FULL = 8'h20;
  localparam logic [7:0] IDX_VOLTAGE_ALERT_THRESHOLDS = 8'h40;
  localparam logic [7:0] IDX_TEMPERATURE_ALERT_THRESHOLDS = 8'h41;
  localparam logic [7:0] IDX_CHARGE_ALERT_THRESHOLDS = 8'h42;
  localparam logic [7:0] IDX_CURRENT_ALERT_THRESHOLDS = 8'h43;
  localparam logic [7:0] IDX_ALERT_CONFIG = 8'h44;
  localparam logic [7:0] IDX_BLOCK_STATE = 8'h45;

  // Flag status bit positions.
  localparam int unsigned BIT_POR = 1;
  localparam int unsigned BIT_CUR_LOW = 2;
  localparam int unsigned BIT_BATT_ABSENT = 3;
  localparam int unsigned BIT_CUR_HIGH = 6;
  localparam int unsigned BIT_ONE_PCT = 7;
  localparam int unsigned BIT_VOLT_LOW = 8;
  localparam int unsigned BIT_TEMP_LOW = 9;
  localparam int unsigned BIT_CHG_LOW = 10;
  localparam int unsigned BIT_INSERTED = 11;
  localparam int unsigned BIT_VOLT_HIGH = 12;
  localparam int unsigned BIT_TEMP_HIGH = 13;
  localparam int unsigned BIT_CHG_HIGH = 14;
  localparam int unsigned BIT_REMOVED = 15;

  // Alert configuration bit positions.
  localparam int unsigned CFG_CURRENT_STICKY = 0;
  localparam int unsigned CFG_VOLTAGE_STICKY = 1;
  localparam int unsigned CFG_TEMPERATURE_STICKY = 2;
  localparam int unsigned CFG_CHARGE_STICKY = 3;

  // Reset values, the time-not-available code and the cycle count limit.
  localparam logic [15:0] FLAG_STATUS_RESET = 16'h8082;
  localparam logic [15:0] PEAK_TRACKER_RESET = 16'h00ff;
  localparam logic [15:0] UNSIGNED_THRESH_RESET = 16'hff00;
  localparam logic [15:0] SIGNED_THRESH_RESET = 16'h7f80;
  localparam logic [3:0] ALERT_CONFIG_RESET = 4'h0;
  localparam logic [15:0] TIME_NOT_AVAILABLE = 16'hffff;
  localparam logic [15:0] CYCLE_COUNT_MAX = 16'hffff;

  // Filter strengths, as right shifts of the error per update.
  localparam int unsigned CAP_FILTER_SHIFT = 2;
  localparam int unsigned AVG_FILTER_SHIFT = 3;

  // Output validity delay after configuration.
  localparam int unsigned VALID_DELAY_MS = 351;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned VALID_DELAY_CYCLES = VALID_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned VALID_CNT_W = 26;

  // One measurement update from the conversion logic.
  typedef struct packed {
    logic [15:0] cellVolt;
    logic [15:0] current;
    logic [15:0] temp;
    logic [7:0] voltQuant;
  } meas_t;

  // One update from the gauging algorithm.
  typedef struct packed {
    logic [15:0] capacity;
    logic [15:0] chargePct;
    logic [15:0] fullCap;
    logic [15:0] timeEmpty;
    logic [15:0] timeFull;
  } alg_t;

endpackage : gauge_regs_pkg

/* File: hw/alert_window_flags.sv */
// Purpose: Low and high threshold flags for one alert class.
// Assumes: Sample strobe marks a fresh reading; keep bits come from a status write.
// Notes: Sticky mode holds a flag until software clears it.
module alert_window_flags #(
  parameter bit SIGNED_CMP = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Reading and thresholds
  input wire logic sample,
  input wire logic [7:0] value,
  input wire logic [7:0] minTh,
  input wire logic [7:0] maxTh,
  input wire logic sticky,
  // Software write of the flag bits
  input wire logic swWrite,
  input wire logic keepLow,
  input wire logic keepHigh,
  // Flags
  output logic lowFlag_r,
  output logic highFlag_r
);

  logic below;
  logic above;
  logic lowKept;
  logic highKept;

  assign below = SIGNED_CMP ? ($signed(value) < $signed(minTh)) : (value < minTh);
  assign above = SIGNED_CMP ? ($signed(value) > $signed(maxTh)) : (value > maxTh);
  assign lowKept = swWrite ? (lowFlag_r & keepLow) : lowFlag_r;
  assign highKept = swWrite ? (highFlag_r & keepHigh) : highFlag_r;

  // A fresh crossing outranks a software clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lowFlag_r <= 1'b0;
      highFlag_r <= 1'b0;
    end else if (sample) begin
      lowFlag_r <= sticky ? (lowKept | below) : below; // see [RL22]
      highFlag_r <= sticky ? (highKept | above) : above; // see [RL22]
    end else begin
      lowFlag_r <= lowKept;
      highFlag_r <= highKept;
    end
  end

  property p_sticky_hold;
    @(posedge clk) disable iff (!rst_b)
      (sticky && lowFlag_r && !swWrite) |=> lowFlag_r;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("Sticky low flag dropped."); // see [RL22]

  property p_auto_clear;
    @(posedge clk) disable iff (!rst_b)
      (sample && !sticky && !above) |=> !highFlag_r;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("High flag not auto-cleared."); // see [RL22]

endmodule : alert_window_flags

/* File: sim/apb_host_model.sv */
// Purpose: Host software stand-in that moves register words over APB.
// Assumes: One aligned 32-bit word per register index, data in the low 16 bits.
// Notes: After the time-zero clear, signals change only by non-blocking assignment right after a rising edge.
module apb_host_model (
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // The request is held until pready is seen high, so a slow slave never loses it.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    pstrb <= wr ? 4'hf : 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host_model

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the gauge status and output register bank.
// Assumes: The host model moves every register word; events are one-cycle pulses.
// Notes: Validity delay is cut to 20 cycles so the run stays short.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gauge_regs_pkg::*;
  logic clk = 1'b0;
  logic rstB, psel, penable, pwrite, pready, pslverr, configDone, batteryAbsent, outputsValid;
  logic porEvent, insertEvent, removeEvent, cycleStep, chargeDone, measUpdate, algUpdate;
  logic [6:0] ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] rd, base;
  logic err;
  meas_t meas;
  alg_t alg, algNew;
  int fails, nCompared, n, stat, mx, mn, avg, dv;
  int seed = 6;
  int evBit[3] = '{BIT_POR, BIT_INSERTED, BIT_REMOVED};
  assign {porEvent, insertEvent, removeEvent, cycleStep, chargeDone, measUpdate, algUpdate} = ev;
  always #4 clk = ~clk;
  // Running-average model: each sample moves the average by a shifted share, at least one step.
  always @(posedge clk) begin
    if (measUpdate === 1'b1) begin
      dv = int'(meas.cellVolt) - avg;
      avg += ((dv >>> AVG_FILTER_SHIFT) != 0) ? (dv >>> AVG_FILTER_SHIFT) : dv;
    end
  end
  apb_host_model apb_host_model_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr);
  gauge_status_and_output_regs #(.VALID_CYCLES(20)) gauge_status_and_output_regs_inst (
    .clk, .rst_b(rstB), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .configDone, .porEvent, .measUpdate, .meas, .algUpdate, .alg, .chargeDone,
    .cycleStep, .insertEvent, .removeEvent, .batteryAbsent, .outputsValid);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Bits 0, 4 and 5 of the status word are undefined, so they are masked off.
  task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] msk;
    msk = (idx == IDX_FLAG_STATUS) ? 16'hffce : 16'hffff;
    apb_host_model_inst.xfer(1'b0, idx, 16'h0000, rd, err);
    check(rd & msk, exp & msk);
  endtask : rdc
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    apb_host_model_inst.xfer(1'b1, idx, d, rd, err);
  endtask : wr
  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
  endtask : pulse
  task automatic end_sim();
    if (fails == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    {rstB, ev, configDone, batteryAbsent, meas, alg} = '0;
    repeat (10) @(posedge clk);
    rstB <= 1'b1;
    rdc(IDX_FLAG_STATUS, FLAG_STATUS_RESET);
    rdc(IDX_VOLTAGE_PEAK_TRACKER, 16'h00ff);
    rdc(IDX_TIME_TO_EMPTY, 16'hffff);
    rdc(IDX_REPORTED_CAPACITY, 16'h0000);
    wr(IDX_FLAG_STATUS, 16'h0000);
    stat = 0;
    rdc(IDX_FLAG_STATUS, 16'h0000);
    foreach (evBit[i]) begin
      pulse(7'h40 >> i);
      stat = stat | (1 << evBit[i]);
      rdc(IDX_FLAG_STATUS, stat[15:0]);
    end
    wr(IDX_FLAG_STATUS, 16'h8002);
    batteryAbsent <= 1'b1;
    rdc(IDX_FLAG_STATUS, 16'h800a);
    mx = 0;
    mn = 255;
    repeat (4) begin
      n = $random(seed) & 255;
      meas.voltQuant <= n[7:0];
      pulse(7'h02);
      mx = (n > mx) ? n : mx;
      mn = (n < mn) ? n : mn;
      rdc(IDX_VOLTAGE_PEAK_TRACKER, {mx[7:0], mn[7:0]});
    end
    wr(IDX_VOLTAGE_PEAK_TRACKER, 16'h00ff);
    rdc(IDX_VOLTAGE_PEAK_TRACKER, 16'h00ff);
    pulse(7'h02);
    rdc(IDX_VOLTAGE_PEAK_TRACKER, {n[7:0], n[7:0]});
    wr(IDX_VOLTAGE_ALERT_THRESHOLDS, 16'h8040);
    meas.cellVolt <= 16'h9000;
    pulse(7'h02);
    rdc(IDX_FLAG_STATUS, 16'h900a);
    meas.cellVolt <= 16'h3000;
    pulse(7'h02);
    rdc(IDX_FLAG_STATUS, 16'h810a);
    wr(IDX_ALERT_CONFIG, 16'h0002);
    meas.cellVolt <= 16'h6000;
    pulse(7'h02);
    rdc(IDX_FLAG_STATUS, 16'h810a);
    batteryAbsent <= 1'b0;
    wr(IDX_FLAG_STATUS, 16'h0000);
    configDone <= 1'b1;
    for (n = 0; n < 100 && outputsValid !== 1'b1; n++) @(posedge clk);
    check({15'h0000, outputsValid}, 16'h0001);
    meas.current <= 16'hff00;
    pulse(7'h02);
    algNew = 80'({$random(seed), $random(seed), $random(seed)});
    algNew.chargePct[15:8] = 8'h37;
    alg <= algNew;
    pulse(7'h01);
    n = algNew.capacity >> CAP_FILTER_SHIFT;
    rdc(IDX_REPORTED_CAPACITY, (n != 0) ? n[15:0] : algNew.capacity);
    rdc(IDX_REPORTED_CHARGE_PCT, algNew.chargePct);
    rdc(IDX_TIME_TO_EMPTY, algNew.timeEmpty);
    rdc(IDX_TIME_TO_FULL, 16'hffff);
    rdc(IDX_FLAG_STATUS, 16'h0080);
    meas.current <= 16'h0100;
    pulse(7'h02);
    rdc(IDX_TIME_TO_EMPTY, 16'hffff);
    rdc(IDX_TIME_TO_FULL, algNew.timeFull);
    pulse(7'h04);
    rdc(IDX_REPORTED_FULL_CAPACITY, algNew.fullCap);
    apb_host_model_inst.xfer(1'b0, IDX_CYCLE_COUNT, 16'h0000, base, err);
    repeat (3) pulse(7'h08);
    rdc(IDX_CYCLE_COUNT, base + 16'h0003);
    rdc(IDX_AVERAGE_CELL_VOLTAGE, avg[15:0]);
    rdc(IDX_CELL_VOLTAGE, 16'h6000);
    apb_host_model_inst.xfer(1'b0, 8'h01, 16'h0000, rd, err);
    check({15'h0000, err}, 16'h0001);
    end_sim();
  end
  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule : testbench
